// [tmhmc_pkg.sv]
// Purpose: constants and types for the two 8-bit timer units
// Assumes: one system clock of 50 MHz, peripheral clock derived from it
// Notes:   register map, field positions and reset values
//
// Contract
// [R1] bit 7 enables counting, clear zeroes counter
// [R2] unit 0 clock select: base, /2 /4 /64 /1024, event
// [R3] unit 1 clock select: base, /4 /16 /64 /4096, slow
// [R4] mode field: interval, pwm, carrier on unit 1
// [R5] bit 1 sets output default level
// [R6] bit 0 gates timer waveform onto output
// [R7] mode registers reset to zero, read write
// [R8] software keeps other bits while enabled
// [R9] software rewrites duty compare before restart
// [R10] carrier clock over six times event clock
// [R11] software starts event counter before unit 0
// [R12] pin level combines direction, latch and timer
// [R13] timer outputs routed to current driver inputs
// [R14] interval match: interrupt, clear, invert output
// [R15] pwm: cycle match active, duty match inactive
// [R16] stop returns interrupt and output to default
// [R17] count clock sources synchronised and counted
package tmhmc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [15:0] TMHMC_TIMER0_MODE_CONTROL = 16'hEE60;
	localparam logic [15:0] TMHMC_TIMER1_MODE_CONTROL = 16'hFF6C;
	localparam logic [7:0]  TMHMC_MODE_RESET          = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TMHMC_ENABLE_BIT = 7;
	localparam int TMHMC_CKS_HI     = 6;
	localparam int TMHMC_CKS_LO     = 4;
	localparam int TMHMC_MODE_HI    = 3;
	localparam int TMHMC_MODE_LO    = 2;
	localparam int TMHMC_LEVEL_BIT  = 1;
	localparam int TMHMC_OUTEN_BIT  = 0;

	// ----------------------------------------------------------------
	// modes, clock division exponents and synchroniser depth
	// ----------------------------------------------------------------
	localparam logic [1:0] TMHMC_MODE_INTERVAL = 2'h0;
	localparam logic [1:0] TMHMC_MODE_CARRIER  = 2'h1;
	localparam logic [1:0] TMHMC_MODE_PWM      = 2'h2;
	localparam int TMHMC_PRESCALE_W = 12;
	localparam int TMHMC_SLOW_W     = 9;
	localparam int TMHMC_SYNC_DEPTH = 3;

	typedef struct packed {
		logic       enable;
		logic [2:0] clock_select;
		logic [1:0] mode;
		logic       default_level;
		logic       output_enable;
	} tmhmc_mode_t;

	typedef struct packed {
		logic [7:0] count;
		logic       use_duty;
		logic       wave;
		logic       irq;
		logic       out;
	} tmhmc_unit_t;

endpackage : tmhmc_pkg

// [tmhmc_unit.sv]
// Purpose: one timer unit: counter, compares, waveform
// Assumes: count tick is a one-cycle pulse on i_clk
// Notes:   carrier mode clears on duty compare match
`timescale 1ns/100ps
module tmhmc_unit
	import tmhmc_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// control
	input  wire tmhmc_mode_t i_mode,
	input  wire logic        i_tick,
	input  wire logic [7:0]  i_cycle_compare,
	input  wire logic [7:0]  i_duty_compare,
	// results
	output logic             o_irq,
	output logic             o_out
);

	tmhmc_unit_t st;
	tmhmc_unit_t next_st;
	logic        cyc_hit;
	logic        duty_hit;

	assign cyc_hit  = st.count == i_cycle_compare;
	assign duty_hit = st.count == i_duty_compare;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st     = st;
		next_st.irq = 1'b0;
		if (!i_mode.enable) begin
			// [R1] [R16] stop, clear, default
			next_st.count    = 8'h00;
			next_st.use_duty = 1'b0;
			// [R5] default output level
			next_st.wave     = i_mode.default_level;
		end else if (i_tick) begin
			// [R17] advance on tick
			next_st.count = st.count + 8'h01;
			case (i_mode.mode)
				TMHMC_MODE_INTERVAL: begin
					// [R14] interval match
					if (cyc_hit) begin
						next_st.count = 8'h00;
						next_st.irq   = 1'b1;
						next_st.wave  = ~st.wave;
					end
				end
				TMHMC_MODE_PWM: begin
					// [R15] cycle and duty switching
					if (!st.use_duty && cyc_hit) begin
						next_st.count    = 8'h00;
						next_st.irq      = 1'b1;
						next_st.wave     = ~i_mode.default_level;
						next_st.use_duty = 1'b1;
					end else if (st.use_duty && duty_hit) begin
						next_st.wave     = i_mode.default_level;
						next_st.use_duty = 1'b0;
					end
				end
				TMHMC_MODE_CARRIER: begin
					if (!st.use_duty && cyc_hit) begin
						next_st.count    = 8'h00;
						next_st.irq      = 1'b1;
						next_st.wave     = ~i_mode.default_level;
						next_st.use_duty = 1'b1;
					end else if (st.use_duty && duty_hit) begin
						next_st.count    = 8'h00;
						next_st.irq      = 1'b1;
						next_st.wave     = i_mode.default_level;
						next_st.use_duty = 1'b0;
					end
				end
				default: begin
					next_st.count = st.count;
				end
			endcase
		end
		// [R6] output gate
		next_st.out = i_mode.output_enable ? next_st.wave
		                                   : i_mode.default_level;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_irq = st.irq;
	assign o_out = st.out;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_stop_clears: assert property (@(posedge i_clk) // [R1]
		disable iff (i_rst)
		!i_mode.enable |=> st.count == 8'h00 && !o_irq)
		else $error("counter not cleared when stopped");
	a_interval_match: assert property (@(posedge i_clk) // [R14]
		disable iff (i_rst)
		i_mode.enable && i_tick && i_mode.mode == TMHMC_MODE_INTERVAL
		&& cyc_hit |=> o_irq && st.count == 8'h00
		&& st.wave != $past(st.wave))
		else $error("interval match effect missing");
	a_pwm_duty: assert property (@(posedge i_clk) // [R15]
		disable iff (i_rst)
		i_mode.enable && i_tick && i_mode.mode == TMHMC_MODE_PWM
		&& st.use_duty && duty_hit
		|=> !o_irq && st.wave == i_mode.default_level)
		else $error("pwm duty match wrong");
	a_stop_default: assert property (@(posedge i_clk) // [R16]
		disable iff (i_rst)
		!i_mode.enable |=> o_out == $past(i_mode.default_level))
		else $error("output not at default while stopped");

endmodule : tmhmc_unit

// [tmhmc_top.sv]
// Purpose: mode control registers and clock selection for two timers
// Assumes: byte register port, event counter output from outside
// Notes:   pin outputs combine timer, direction and latch
`timescale 1ns/100ps
module tmhmc_top
	import tmhmc_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// register port
	input  wire logic [15:0] i_addr,
	input  wire logic        i_wr,
	input  wire logic [7:0]  i_wdata,
	output logic [7:0]       o_rdata,
	// outside sources
	input  wire logic        i_event_counter_a,
	input  wire logic        i_event_counter_b,
	input  wire logic        i_slow_clock,
	// compares
	input  wire logic [7:0]  i_unit0_cycle_compare,
	input  wire logic [7:0]  i_unit0_duty_compare,
	input  wire logic [7:0]  i_unit1_cycle_compare,
	input  wire logic [7:0]  i_unit1_duty_compare,
	// port controls
	input  wire logic [1:0]  i_pin_direction_bit,
	input  wire logic [1:0]  i_pin_output_latch,
	// results
	output logic [1:0]       o_timer_interrupt_request,
	output logic [1:0]       o_timer_output,
	output logic [1:0]       o_pin_out,
	output logic [1:0]       o_pin_oe_n,
	output logic [3:0]       o_driver_pwm
);

	typedef struct packed {
		tmhmc_mode_t [1:0]            mode;
		logic [TMHMC_PRESCALE_W-1:0] pre;
		logic [TMHMC_PRESCALE_W-1:0] pre_q;
		logic [TMHMC_SLOW_W-1:0]     slow;
		logic [TMHMC_SLOW_W-1:0]     slow_q;
		logic [TMHMC_SYNC_DEPTH-1:0] ev_sync;
		logic [TMHMC_SYNC_DEPTH-1:0] rl_sync;
		logic [TMHMC_SYNC_DEPTH-1:0] evb_sync;
		logic                        ev_lvl;
		logic                        rl_lvl;
		logic                        evb_lvl;
		logic [7:0]                  rdata;
		logic [1:0]                  pin_out;
		logic [1:0]                  pin_oe_n;
		logic [3:0]                  drv;
	} tmhmc_top_t;

	tmhmc_top_t st;
	tmhmc_top_t next_st;
	logic [1:0] tick;
	logic [1:0] irq;
	logic [1:0] tout;
	logic       rl_rise;
	logic       ev_rise;

	// both groups enter on the second and third stage agreeing
	assign ev_rise = st.ev_sync[2] & st.ev_sync[1] & ~st.ev_lvl;
	assign rl_rise = st.rl_sync[2] & st.rl_sync[1] & ~st.rl_lvl;

	function automatic logic edge_of(input logic [11:0] now,
	                                 input logic [11:0] was,
	                                 input int          bitn);
		edge_of = now[bitn] & ~was[bitn];
	endfunction : edge_of

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		// [R7] byte writes to the two registers
		if (i_wr && i_addr == TMHMC_TIMER0_MODE_CONTROL) begin
			next_st.mode[0] = tmhmc_mode_t'(i_wdata);
		end
		if (i_wr && i_addr == TMHMC_TIMER1_MODE_CONTROL) begin
			next_st.mode[1] = tmhmc_mode_t'(i_wdata);
		end
		case (i_addr)
			TMHMC_TIMER0_MODE_CONTROL: next_st.rdata = st.mode[0];
			TMHMC_TIMER1_MODE_CONTROL: next_st.rdata = st.mode[1];
			default:                   next_st.rdata = 8'h00;
		endcase
		// [R17] prescalers and synchronisers
		next_st.pre      = st.pre + 12'h001;
		next_st.pre_q    = st.pre;
		next_st.ev_sync  = {st.ev_sync[1:0], i_event_counter_a};
		next_st.rl_sync  = {st.rl_sync[1:0], i_slow_clock};
		next_st.evb_sync = {st.evb_sync[1:0], i_event_counter_b};
		if (st.ev_sync[2] == st.ev_sync[1]) begin
			next_st.ev_lvl = st.ev_sync[2];
		end
		if (st.rl_sync[2] == st.rl_sync[1]) begin
			next_st.rl_lvl = st.rl_sync[2];
		end
		if (st.evb_sync[2] == st.evb_sync[1]) begin
			next_st.evb_lvl = st.evb_sync[2];
		end
		next_st.slow   = rl_rise ? st.slow + 9'h001 : st.slow;
		next_st.slow_q = st.slow;
		// [R12] pin from timer, latch and direction
		for (int u = 0; u < 2; u++) begin
			next_st.pin_oe_n[u] = i_pin_direction_bit[u];
			next_st.pin_out[u]  = tout[u] | i_pin_output_latch[u];
		end
		// [R13] driver routing
		next_st.drv = {st.ev_lvl, tout[1], tout[0], st.evb_lvl};
	end

	// [R2] unit 0 clock select
	always_comb begin
		case (st.mode[0].clock_select)
			3'h0: tick[0] = 1'b1;
			3'h1: tick[0] = edge_of(st.pre, st.pre_q, 0);
			3'h2: tick[0] = edge_of(st.pre, st.pre_q, 1);
			3'h3: tick[0] = edge_of(st.pre, st.pre_q, 5);
			3'h4: tick[0] = edge_of(st.pre, st.pre_q, 9);
			3'h5: tick[0] = ev_rise;
			default: tick[0] = 1'b0;
		endcase
	end

	// [R3] unit 1 clock select
	always_comb begin
		case (st.mode[1].clock_select)
			3'h0: tick[1] = 1'b1;
			3'h1: tick[1] = edge_of(st.pre, st.pre_q, 1);
			3'h2: tick[1] = edge_of(st.pre, st.pre_q, 3);
			3'h3: tick[1] = edge_of(st.pre, st.pre_q, 5);
			3'h4: tick[1] = edge_of(st.pre, st.pre_q, 11);
			3'h5: tick[1] = rl_rise & st.slow[6:0] == 7'h7F;
			3'h6: tick[1] = rl_rise & st.slow == 9'h1FF;
			default: tick[1] = rl_rise;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// timer units
	// ----------------------------------------------------------------
	tmhmc_mode_t [1:0] umode;
	always_comb begin
		umode = st.mode;
		// [R4] unit 0 has no carrier mode
		if (st.mode[0].mode == TMHMC_MODE_CARRIER) begin
			umode[0].mode = 2'h3;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_unit
			tmhmc_unit u_unit (
				.i_clk           (i_clk),
				.i_rst           (i_rst),
				.i_mode          (umode[g]),
				.i_tick          (tick[g]),
				.i_cycle_compare (g == 0 ? i_unit0_cycle_compare
				                         : i_unit1_cycle_compare),
				.i_duty_compare  (g == 0 ? i_unit0_duty_compare
				                         : i_unit1_duty_compare),
				.o_irq           (irq[g]),
				.o_out           (tout[g])
			);
		end
	endgenerate

	assign o_timer_interrupt_request = irq;
	assign o_timer_output            = tout;
	assign o_rdata                   = st.rdata;
	assign o_pin_out                 = st.pin_out;
	assign o_pin_oe_n                = st.pin_oe_n;
	assign o_driver_pwm              = st.drv;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_reg_write: assert property (@(posedge i_clk) // [R7]
		disable iff (i_rst)
		i_wr && i_addr == TMHMC_TIMER0_MODE_CONTROL
		|=> st.mode[0] == $past(i_wdata))
		else $error("mode register write lost");
	a_stop_no_irq: assert property (@(posedge i_clk) // [R1]
		disable iff (i_rst)
		!st.mode[1].enable [*2] |-> !irq[1])
		else $error("interrupt while stopped");
	a_gate_output: assert property (@(posedge i_clk) // [R6]
		disable iff (i_rst)
		!st.mode[0].output_enable [*2]
		|-> tout[0] == $past(st.mode[0].default_level))
		else $error("output not gated");
	a_pin_dir: assert property (@(posedge i_clk) // [R12]
		disable iff (i_rst)
		1'b1 |=> o_pin_oe_n == $past(i_pin_direction_bit))
		else $error("pin enable does not follow direction");
	a_slow_tick: assert property (@(posedge i_clk) // [R3]
		disable iff (i_rst)
		st.mode[1].clock_select == 3'h7 && rl_rise |-> tick[1])
		else $error("slow clock tick missed");
	a_driver_route: assert property (@(posedge i_clk) // [R13]
		disable iff (i_rst)
		1'b1 |=> o_driver_pwm[2:1] == $past(tout))
		else $error("timer outputs not routed to driver");

endmodule : tmhmc_top

// [tmhmc_bench.sv]
// Purpose: self-checking bench for the two-unit timer mode control
// Assumes: peripheral clock equals i_clk, inputs driven on falling edge
// Notes:   event counter a and slow sources toggle every 4 cycles in background
`timescale 1ns/100ps
module tmhmc_bench;
	import tmhmc_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        i_clk, i_rst, i_wr, i_eva, i_evb, i_slow;
	logic [15:0] i_addr;
	logic [7:0]  i_wdata, o_rdata, c0, d0, c1, d1;
	logic [1:0]  i_dir, i_latch, o_irq, o_tout, o_pin, o_oe_n;
	logic [3:0]  o_drv;
	logic [1:0]  div;
	int          num_errors, n_checks, cyc;
	localparam logic [15:0] A0 = TMHMC_TIMER0_MODE_CONTROL;
	localparam logic [15:0] A1 = TMHMC_TIMER1_MODE_CONTROL;

	tmhmc_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
		.i_event_counter_a(i_eva), .i_event_counter_b(i_evb),
		.i_slow_clock(i_slow), .i_unit0_cycle_compare(c0),
		.i_unit0_duty_compare(d0), .i_unit1_cycle_compare(c1),
		.i_unit1_duty_compare(d1), .i_pin_direction_bit(i_dir),
		.i_pin_output_latch(i_latch), .o_timer_interrupt_request(o_irq),
		.o_timer_output(o_tout), .o_pin_out(o_pin), .o_pin_oe_n(o_oe_n),
		.o_driver_pwm(o_drv));

	// ----------------------------------------------------------------
	// clock, sources, timeout
	// ----------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	always @(negedge i_clk) begin
		div <= div + 2'h1;
		if (div == 2'h3) begin
			i_eva  <= ~i_eva;
			i_slow <= ~i_slow;
		end
	end
	always @(posedge i_clk) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			num_errors = num_errors + 1;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_addr  = a;
		i_wdata = d;
		i_wr    = 1'b1;
		@(negedge i_clk);
		i_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge i_clk);
		i_addr = a;
		@(posedge i_clk);
		#1 d = o_rdata;
	endtask : rd
	task automatic wait_irq(input int u, output int n);
		n = 0;
		do begin
			@(posedge i_clk);
			#1 n = n + 1;
		end while (o_irq[u] !== 1'b1 && n < 10000);
	endtask : wait_irq
	task automatic idle(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : idle

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		logic [7:0] d;
		rd(A0, d);
		chk(d, TMHMC_MODE_RESET);
		rd(A1, d);
		chk(d, TMHMC_MODE_RESET);
		wr(16'h1234, 8'hFF);
		rd(16'h1234, d);
		chk(d, 8'h00);
		wr(A0, 8'h5E);
		wr(A1, 8'h7E);
		rd(A0, d);
		chk(d, 8'h5E);
		rd(A1, d);
		chk(d, 8'h7E);
		wr(A0, 8'h00);
		wr(A1, 8'h00);
	endtask : t_regs
	task automatic t_interval();
		int n;
		logic o;
		c0 = 8'h03;
		wr(A0, 8'h01);
		wr(A0, 8'h81);
		wait_irq(0, n);
		chk(16'(n >= 4 && n <= 7), 16'h1);
		o = o_tout[0];
		wait_irq(0, n);
		chk(n, 16'h4);
		chk(o_tout[0], {~o});
		wr(A0, 8'h01);
		idle(2);
		chk({o_irq[0], o_tout[0]}, 2'b00);
		wr(A0, 8'h03);
		idle(2);
		chk(o_tout[0], 1'b1);
		wr(A0, 8'h02);
		wr(A0, 8'h82);
		wait_irq(0, n);
		chk(o_tout[0], 1'b1);
		wait_irq(0, n);
		chk(o_tout[0], 1'b1);
		wr(A0, 8'h02);
		d0 = 8'h01;
		wr(A0, 8'h09);
		wr(A0, 8'h89);
		wait_irq(0, n);
		chk(o_tout[0], 1'b1);
		wait_irq(0, n);
		chk(n, 16'h4);
		wr(A0, 8'h09);
		wr(A0, 8'h04);
		wr(A0, 8'h84);
		wait_irq(0, n);
		chk(16'(n >= 60), 16'h1);
		wr(A0, 8'h04);
	endtask : t_interval
	task automatic t_clocks();
		int n;
		int p0 [6] = '{1, 2, 4, 64, 1024, 8};
		int p1 [8] = '{1, 4, 16, 64, 4096, 1024, 4096, 8};
		c0 = 8'h00;
		c1 = 8'h00;
		for (int k = 0; k < 14; k++) begin
			logic [15:0] a;
			logic [2:0]  s;
			a = (k < 6) ? A0 : A1;
			s = (k < 6) ? 3'(k) : 3'(k - 6);
			wr(a, {1'b0, s, 4'h0});
			wr(a, {1'b1, s, 4'h0});
			wait_irq((k < 6) ? 0 : 1, n);
			wait_irq((k < 6) ? 0 : 1, n);
			chk(n, (k < 6) ? p0[k] : p1[k - 6]);
			wr(a, {1'b0, s, 4'h0});
		end
	endtask : t_clocks
	task automatic t_pwm();
		int n, hi, irqs;
		c1 = 8'h07;
		d1 = 8'h02;
		wr(A1, 8'h09);
		wr(A1, 8'h89);
		wait_irq(1, n);
		hi = 0;
		irqs = 0;
		repeat (8) begin
			hi = hi + ((o_tout[1] !== 1'b0) ? 1 : 0);
			@(posedge i_clk);
			#1 irqs = irqs + ((o_irq[1] === 1'b1) ? 1 : 0);
		end
		chk(hi, 16'h3);
		chk(irqs, 16'h1);
		wr(A1, 8'h09);
		d1 = 8'h02;
		wr(A1, 8'h05);
		wr(A1, 8'h85);
		wait_irq(1, n);
		wait_irq(1, n);
		chk(n, 16'h3);
		wr(A1, 8'h05);
	endtask : t_pwm
	task automatic t_pins();
		int ones;
		i_evb = 1'b1;
		i_dir = 2'b10;
		i_latch = 2'b00;
		wr(A0, 8'h03);
		wr(A1, 8'h03);
		idle(6);
		chk(o_pin, 2'b11);
		chk(o_oe_n, 2'b10);
		chk(o_drv[2:0], 3'b111);
		@(negedge i_clk);
		i_evb = 1'b0;
		i_latch = 2'b01;
		wr(A0, 8'h01);
		wr(A1, 8'h01);
		idle(6);
		chk(o_pin, 2'b01);
		chk(o_drv[2:0], 3'b000);
		ones = 0;
		repeat (8) begin
			@(posedge i_clk);
			#1 ones = ones + ((o_drv[3] === 1'b1) ? 1 : 0);
		end
		chk(ones, 16'h4);
	endtask : t_pins
	task automatic close_out();
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		num_errors = 0;
		n_checks = 0;
		cyc = 0;
		div = 2'h0;
		i_rst = 1'b1;
		{i_wr, i_eva, i_evb, i_slow} = 4'h0;
		i_addr = 16'h0000;
		i_wdata = 8'h00;
		{c0, d0, c1, d1} = 32'h0000_0000;
		i_dir = 2'b11;
		i_latch = 2'b00;
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		i_rst = 1'b0;
		t_regs();
		t_interval();
		t_clocks();
		t_pwm();
		t_pins();
		close_out();
	end
endmodule : tmhmc_bench
